// ---- hw/mdt_defines.svh ----
// constants of the motor dead time generator: offsets, fields, reset values, counts
`ifndef MDT_DEFINES_SVH
`define MDT_DEFINES_SVH

// register byte addresses on the apb bus
`define MDT_CFG_ADDR 8'h00
`define MDT_STATUS_ADDR 8'h04

// fields of dead_time_config
`define MDT_DELAY_LSB 0
`define MDT_DELAY_MSB 5
`define MDT_RANGE_LO_BIT 4
`define MDT_RANGE_HI_BIT 5
`define MDT_ENABLE_BIT 6
`define MDT_THREE_PHASE_BIT 7

// fields of the status word
`define MDT_STAT_LOCK_BIT 0
`define MDT_STAT_DRIVE_LSB 8

// reset values
`define MDT_CFG_RESET 8'hff

// timing: dead time unit as a shift count of input clock periods (2, 4, 8 clocks), and the base of the long ranges
`define MDT_UNIT_SHORT_SHIFT 1
`define MDT_UNIT_MID_SHIFT 2
`define MDT_UNIT_LONG_SHIFT 3
`define MDT_LONG_BASE 9'h011
`define MDT_CNT_MAX 9'h1ff

`endif

// ---- hw/mdt_pkg.sv ----
// types of the motor dead time generator
package mdt_pkg;

  // state of one delay channel
  typedef struct packed {
    logic prev;
    logic [8:0] cnt;
    logic a;
    logic b;
  } mdt_chan_state_t;

  // state of the top level
  typedef struct packed {
    logic [7:0] cfg;
    logic locked;
    logic [31:0] prdata;
    logic [5:0] drive;
    logic feed;
  } mdt_top_state_t;

endpackage

// ---- hw/mdt_delay_chan.sv ----
// one dead time channel: complementary a/b pair with delayed rising edges
`timescale 1ns/10ps
`include "mdt_defines.svh"

module mdt_delay_chan (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // phase input and programmed delay in clock cycles
  input wire logic phase_i,
  input wire logic [8:0] delay_cycles_i,
  // delayed pair
  output logic a_o,
  output logic b_o
);

  mdt_pkg::mdt_chan_state_t q; // registered state
  mdt_pkg::mdt_chan_state_t next_q; // next state

  // next state: count cycles since the last phase edge
  always_comb
  begin
    next_q = q;
    next_q.prev = phase_i;
    if (phase_i != q.prev)
    begin
      next_q.cnt = 9'h000;
    end
    else if (q.cnt != `MDT_CNT_MAX)
    begin
      // saturate so a long steady level never wraps back into a false gap
      next_q.cnt = q.cnt + 9'h001;
    end
    next_q.a = phase_i & (next_q.cnt >= delay_cycles_i);
    next_q.b = ~phase_i & (next_q.cnt >= delay_cycles_i);
    // a phase shorter than the delay never reaches the count, so its pulse is dropped
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign a_o = q.a;
  assign b_o = q.b;

  // both switches of a half bridge are never on together
  AST_NO_OVERLAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(a_o && b_o)) else $error("a and b high together");

  // a rise comes exactly at the programmed count
  AST_RISE_AT_DELAY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(a_o) |-> (q.cnt == delay_cycles_i) && q.prev) else $error("a rose off delay");

  // a falling phase drops a at once
  AST_FALL_FAST: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!phase_i && q.prev) |=> !a_o) else $error("a did not follow phase fall");

endmodule

// ---- hw/mdt_top.sv ----
// motor dead time generator top: config register, mode steering, three delay channels
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "mdt_defines.svh"

// What this block does
// - three generators, 6-bit setting, outputs a/b
// - a follows phase, rise delayed
// - b inverts phase, rise delayed
// - pulse shorter than delay is dropped
// - range 0: unit two clocks, 1-32
// - range 1: unit four or eight, from 17
// - one setting shared by all channels
// - delay counts raw motor input clock
// - delay setting accepts one write only
// - enable bit gates insertion per mode
// - enable bit read-only in three-phase mode
// - disabled three-phase gives plain complements
// - config resets to all ones
// - single write keeps enable at one
// - six-step feed: phase u or window
// - six-step: enable bit freely writable
// - six-step pairs 0:1, 2:3, 4:5
// - both channels off: pair off
// - one active: complementary, active channel gets a
// - both active: pair forced off
module mdt_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pwm sources
  input wire logic [2:0] phase_pwm_i,
  input wire logic meas_window_i,
  input wire logic current_mode_i,
  // pwm manager side in six-step mode
  input wire logic [5:0] channel_on_state_i,
  input wire logic [5:0] mgr_out_i,
  output logic pwm_feed_o,
  // mode bits seen by the rest of the peripheral
  output logic three_phase_select_o,
  output logic dead_insert_enable_o,
  // motor outputs
  output logic [5:0] motor_drive_out_o
);

  mdt_pkg::mdt_top_state_t q; // registered state
  mdt_pkg::mdt_top_state_t next_q; // next state

  logic three_phase; // current mode bit
  logic ins_en; // current enable bit
  logic [5:0] setting; // current delay setting
  logic [8:0] delay_cycles; // delay in input clock cycles
  logic [8:0] units; // delay in dead time units
  logic [2:0] gen_in; // input of each generator
  logic [2:0] gen_a; // delayed a of each generator
  logic [2:0] gen_b; // delayed b of each generator
  logic [5:0] drive_c; // combinational motor outputs
  logic wr_cfg; // write taken on the config word
  logic rd_setup; // setup phase of a read
  logic mapped; // address hits a register

  assign three_phase = q.cfg[`MDT_THREE_PHASE_BIT];
  assign ins_en = q.cfg[`MDT_ENABLE_BIT];
  assign setting = q.cfg[`MDT_DELAY_MSB:`MDT_DELAY_LSB];

  // address decode
  always_comb
  begin
    mapped = (paddr_i == `MDT_CFG_ADDR) || (paddr_i == `MDT_STATUS_ADDR);
    rd_setup = psel_i && !penable_i && !pwrite_i;
    wr_cfg = psel_i && penable_i && pwrite_i && (paddr_i == `MDT_CFG_ADDR);
  end

  // zero wait states: read data is caught in setup, so access always completes
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o = q.prdata;

  // delay length from the shared setting
  always_comb
  begin
    units = 9'h000;
    delay_cycles = 9'h000;
    if (!setting[`MDT_RANGE_HI_BIT])
    begin
      units = {4'h0, setting[4:0]} + 9'h001;
      delay_cycles = units << `MDT_UNIT_SHORT_SHIFT;
    end
    else
    begin
      units = {5'h00, setting[3:0]} + `MDT_LONG_BASE;
      if (setting[`MDT_RANGE_LO_BIT])
      begin
        delay_cycles = units << `MDT_UNIT_LONG_SHIFT;
      end
      else
      begin
        delay_cycles = units << `MDT_UNIT_MID_SHIFT;
      end
    end
    // raw clock count
    // the count runs on ref_clk_i directly; no prescaler sits in its path
  end

  // one generator per phase, or per channel pair in six-step mode
  // three generators
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_pair
      always_comb
      begin
        if (three_phase)
        begin
          gen_in[k] = phase_pwm_i[k];
        end
        else if (channel_on_state_i[2*k])
        begin
          gen_in[k] = mgr_out_i[2*k];
        end
        else
        begin
          gen_in[k] = mgr_out_i[2*k+1];
        end
      end

      mdt_delay_chan u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .phase_i(gen_in[k]),
        .delay_cycles_i(delay_cycles),
        .a_o(gen_a[k]),
        .b_o(gen_b[k])
      );

      // output steering for the pair
      // mode dependent enable
      always_comb
      begin
        if (three_phase && ins_en)
        begin
          // dead time inserted on both switches
          drive_c[2*k+1 -: 2] = {gen_b[k], gen_a[k]};
        end
        else if (three_phase)
        begin
          drive_c[2*k+1 -: 2] = {~phase_pwm_i[k], phase_pwm_i[k]};
        end
        else if (!ins_en)
        begin
          // six-step without insertion: manager drives the pins
          drive_c[2*k+1 -: 2] = mgr_out_i[2*k+1 -: 2];
        end
        else
        begin
          case (channel_on_state_i[2*k+1 -: 2])
            2'b01:
            begin
              drive_c[2*k+1 -: 2] = {gen_b[k], gen_a[k]};
            end
            2'b10:
            begin
              drive_c[2*k+1 -: 2] = {gen_a[k], gen_b[k]};
            end
            2'b11:
            begin
              drive_c[2*k+1 -: 2] = 2'b00;
            end
            default:
            begin
              // idle pair stays off for zero-crossing sensing
              drive_c[2*k+1 -: 2] = 2'b00;
            end
          endcase
        end
      end

      // both active in paired mode gives both off
      AST_BOTH_ACTIVE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!three_phase && ins_en && (channel_on_state_i[2*k+1 -: 2] == 2'b11))
        |=> (motor_drive_out_o[2*k+1 -: 2] == 2'b00)) else $error("active pair not off");

      // idle pair in paired mode stays off
      AST_IDLE_PAIR_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!three_phase && ins_en && (channel_on_state_i[2*k+1 -: 2] == 2'b00))
        |=> (motor_drive_out_o[2*k+1 -: 2] == 2'b00)) else $error("idle pair driven");

      // plain complement when insertion is off in three-phase mode
      AST_PLAIN_COMP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (three_phase && !ins_en) |=> (motor_drive_out_o[2*k] == $past(phase_pwm_i[k]))
        && (motor_drive_out_o[2*k+1] == !$past(phase_pwm_i[k])))
        else $error("outputs not plain complements");

      // inserted three-phase pair comes straight from its generator, one register later
      AST_THREE_PHASE_PAIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (three_phase && ins_en) |=> (motor_drive_out_o[2*k] == $past(gen_a[k]))
        && (motor_drive_out_o[2*k+1] == $past(gen_b[k])))
        else $error("three-phase pair not from generator");

      // a lone active channel carries a, its partner carries b
      AST_LONE_CHANNEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!three_phase && ins_en && (channel_on_state_i[2*k+1 -: 2] == 2'b01))
        |=> (motor_drive_out_o[2*k] == $past(gen_a[k]))
        && (motor_drive_out_o[2*k+1] == $past(gen_b[k])))
        else $error("lone channel pair wrong");
    end
  endgenerate

  // next state: register writes, read capture, output registers
  always_comb
  begin
    next_q = q;
    next_q.drive = drive_c;
    if (!three_phase && current_mode_i)
    begin
      next_q.feed = meas_window_i;
    end
    else
    begin
      next_q.feed = phase_pwm_i[0];
    end
    if (wr_cfg)
    begin
      if (!q.locked)
      begin
        next_q.cfg[`MDT_DELAY_MSB:`MDT_DELAY_LSB] = pwdata_i[`MDT_DELAY_MSB:`MDT_DELAY_LSB];
        next_q.locked = 1'b1;
      end
      // mode bit stays writable so the delay can be set before leaving three-phase
      next_q.cfg[`MDT_THREE_PHASE_BIT] = pwdata_i[`MDT_THREE_PHASE_BIT];
      if (!three_phase)
      begin
        next_q.cfg[`MDT_ENABLE_BIT] = pwdata_i[`MDT_ENABLE_BIT];
      end
      // read-only in three-phase; a first full write keeps it at one
    end
    // read data is taken in the setup phase and held through the access phase
    if (rd_setup)
    begin
      next_q.prdata = 32'h0000_0000;
      if (paddr_i == `MDT_CFG_ADDR)
      begin
        next_q.prdata[7:0] = q.cfg;
      end
      else if (paddr_i == `MDT_STATUS_ADDR)
      begin
        next_q.prdata[`MDT_STAT_LOCK_BIT] = q.locked;
        next_q.prdata[`MDT_STAT_DRIVE_LSB +: 6] = q.drive;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q.cfg <= `MDT_CFG_RESET;
      q.locked <= 1'b0;
      q.prdata <= 32'h0000_0000;
      q.drive <= 6'h00;
      q.feed <= 1'b0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign motor_drive_out_o = q.drive;
  assign pwm_feed_o = q.feed;
  assign three_phase_select_o = three_phase;
  assign dead_insert_enable_o = ins_en;

  // delay setting never changes once locked
  AST_WRITE_ONCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (q.locked && wr_cfg) |=> $stable(q.cfg[`MDT_DELAY_MSB:`MDT_DELAY_LSB]))
    else $error("delay changed after lock");

  // enable bit is frozen while three-phase is selected
  AST_ENABLE_RO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (three_phase && wr_cfg) |=> $stable(q.cfg[`MDT_ENABLE_BIT]))
    else $error("enable changed in three-phase");

  // enable bit follows a write in six-step mode
  AST_ENABLE_RW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!three_phase && wr_cfg) |=> (q.cfg[`MDT_ENABLE_BIT] == $past(pwdata_i[`MDT_ENABLE_BIT])))
    else $error("enable write lost in six-step");

  // first write after reset lands the delay setting
  AST_FIRST_WRITE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!q.locked && wr_cfg) |=> q.locked
    && (q.cfg[`MDT_DELAY_MSB:`MDT_DELAY_LSB] == $past(pwdata_i[`MDT_DELAY_MSB:`MDT_DELAY_LSB])))
    else $error("first write not taken");

  // short range delay length
  AST_SHORT_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !setting[`MDT_RANGE_HI_BIT] |-> (delay_cycles == ({4'h0, setting[4:0]} + 9'h001) * 9'h002))
    else $error("short range delay wrong");

  // longest code gives 32 units of eight clocks
  AST_LONG_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (setting == 6'h3f) |-> (delay_cycles == 9'h100)) else $error("long range delay wrong");

  // six-step feed picks the window in current mode
  AST_FEED_SELECT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!three_phase && current_mode_i) |=> (pwm_feed_o == $past(meas_window_i)))
    else $error("feed select wrong");

  // voltage mode six-step feeds phase u onward
  AST_FEED_PHASE_U: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!three_phase && !current_mode_i) |=> (pwm_feed_o == $past(phase_pwm_i[0])))
    else $error("feed not phase u");

  // six-step without insertion hands the manager outputs straight through
  AST_DIRECT_SIX: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!three_phase && !ins_en) |=> (motor_drive_out_o == $past(mgr_out_i)))
    else $error("six-step outputs not direct");

  // the lock only clears at reset, so a stray write can never reopen the delay
  AST_LOCK_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    q.locked |=> q.locked) else $error("lock flag dropped");

  // a write to the status word leaves the config untouched
  AST_STATUS_RO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (psel_i && penable_i && pwrite_i && (paddr_i == `MDT_STATUS_ADDR)) |=> $stable(q.cfg))
    else $error("status write changed config");

endmodule

// ---- verification/mdt_power_stage.sv ----
// power stage model: half bridges that count any leg driven both ways at once
`timescale 1ns/10ps
module mdt_power_stage (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // gate drive from the block, even bit high side, odd bit low side
  input wire logic [5:0] motor_drive_i,
  // cycles seen with a shorted leg
  output int shoot_count_o
);
  // a real bridge would short the supply here, so every such cycle is counted
  // no cross conduction
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      shoot_count_o <= 0;
    else if ((motor_drive_i[0] & motor_drive_i[1]) | (motor_drive_i[2] & motor_drive_i[3]) |
             (motor_drive_i[4] & motor_drive_i[5]))
      shoot_count_o <= shoot_count_o + 1;
  end
endmodule

// ---- verification/mdt_top_tb.sv ----
// self-checking bench of the dead time generator top
`timescale 1ns/10ps
`include "mdt_defines.svh"
module mdt_top_tb;
  // clock, reset and apb master signals
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic stage_rst = 1'h1; // power stage count survives the mid-run resets
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, feed, tp_sel, ins_en;
  // pwm sources, manager side and motor outputs
  logic [2:0] phase = 3'h0;
  logic meas_win = 1'h0, cur_mode = 1'h0;
  logic [5:0] on_state = 6'h00, mgr = 6'h00, drv;
  int shoots;
  int bad_count = 0;
  int comparisons = 0;
  // settings tried after separate resets, since the delay takes one write only
  logic [7:0] codes [5] = '{8'h80, 8'h9f, 8'ha0, 8'hb3, 8'hbf};
  // pair patterns: on bits, manager bits, expected pair outputs
  logic [1:0] tab [5][3] = '{'{2'h1, 2'h1, 2'h1}, '{2'h2, 2'h2, 2'h2}, '{2'h3, 2'h3, 2'h0},
                            '{2'h0, 2'h0, 2'h0}, '{2'h1, 2'h0, 2'h2}};

  always #2 ref_clk_i = ~ref_clk_i;

  mdt_top u_mdt_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .phase_pwm_i(phase), .meas_window_i(meas_win),
    .current_mode_i(cur_mode), .channel_on_state_i(on_state), .mgr_out_i(mgr),
    .pwm_feed_o(feed), .three_phase_select_o(tp_sel), .dead_insert_enable_o(ins_en),
    .motor_drive_out_o(drv));

  mdt_power_stage u_mdt_power_stage (
    .ref_clk_i(ref_clk_i), .rst_i(stage_rst), .motor_drive_i(drv), .shoot_count_o(shoots));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge ref_clk_i);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'h1;
    // no cycle count is assumed; only the watchdog ends a stuck wait
    do
    begin
      @(posedge ref_clk_i);
    end
    while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'h0, a, 32'h0, rd, e);
    check("read data", rd, exp);
  endtask

  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'h0;
  endtask

  // delay in clock cycles for a 6-bit setting
  function automatic int exp_delay(input logic [5:0] s);
    if (!s[5])
      return (int'(s[4:0]) + 1) * 2;
    return (int'(s[3:0]) + 17) * (s[4] ? 8 : 4);
  endfunction

  // moves one phase and counts cycles from the falling output to the rising one
  task automatic measure(input int ch, input logic lvl, input int exp);
    int n;
    int fb;
    fb = lvl ? 2 * ch + 1 : 2 * ch;
    @(posedge ref_clk_i);
    phase[ch] <= lvl;
    for (n = 0; n < 20 && drv[fb] !== 1'h0; n++)
      @(posedge ref_clk_i);
    for (n = 0; n < 600 && drv[fb ^ 1] !== 1'h1; n++)
      @(posedge ref_clk_i);
    check("edge delay", n, exp);
  endtask

  task automatic t_reset_regs();
    logic [31:0] q;
    logic e;
    rdchk(`MDT_CFG_ADDR, 32'hff);
    check("mode bits", {tp_sel, ins_en}, 2'h3);
    apb(1'h0, 8'h08, 32'h0, q, e);
    check("unmapped error", e, 1'h1);
    check("unmapped data", q, 32'h0);
    // a refused write must not use up the single delay write
    wr(8'h0c, 32'h0);
    wr(`MDT_STATUS_ADDR, 32'h0);
    rdchk(`MDT_CFG_ADDR, 32'hff);
    $display("test reset_regs done");
  endtask

  task automatic t_codes();
    int d;
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      d = exp_delay(codes[i][5:0]);
      wr(`MDT_CFG_ADDR, {24'h0, codes[i]});
      rdchk(`MDT_CFG_ADDR, {24'h0, codes[i] | 8'h40});
      wr(`MDT_CFG_ADDR, {24'h0, codes[i] ^ 8'h05});
      rdchk(`MDT_CFG_ADDR, {24'h0, codes[i] | 8'h40});
      repeat (300) @(posedge ref_clk_i);
      measure(i % 3, 1'h1, d);
      measure(i % 3, 1'h0, d);
    end
    $display("test codes done");
  endtask

  task automatic t_short_pulse();
    logic hi;
    hi = 1'h0;
    @(posedge ref_clk_i);
    phase[1] <= 1'h1;
    repeat (10) @(posedge ref_clk_i);
    phase[1] <= 1'h0;
    repeat (300)
    begin
      @(posedge ref_clk_i);
      hi = hi | (drv[2] === 1'h1);
    end
    check("short pulse", hi, 1'h0);
    check("low side back", drv[3], 1'h1);
    $display("test short_pulse done");
  endtask

  task automatic t_plain();
    do_reset();
    wr(`MDT_CFG_ADDR, 32'h00);
    rdchk(`MDT_CFG_ADDR, 32'h40);
    wr(`MDT_CFG_ADDR, 32'h00);
    rdchk(`MDT_CFG_ADDR, 32'h00);
    wr(`MDT_CFG_ADDR, 32'h80);
    wr(`MDT_CFG_ADDR, 32'hc0);
    rdchk(`MDT_CFG_ADDR, 32'h80);
    check("mode bits", {tp_sel, ins_en}, 2'h2);
    phase <= 3'h5;
    repeat (3) @(posedge ref_clk_i);
    check("plain pairs", drv, 6'h19);
    phase <= 3'h2;
    repeat (3) @(posedge ref_clk_i);
    check("plain pairs", drv, 6'h26);
    rdchk(`MDT_STATUS_ADDR, 32'h0000_2601);
    $display("test plain done");
  endtask

  task automatic t_six_step();
    do_reset();
    phase <= 3'h1;
    wr(`MDT_CFG_ADDR, 32'h40);
    rdchk(`MDT_CFG_ADDR, 32'h40);
    check("feed voltage", feed, 1'h1);
    cur_mode <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    check("feed current", feed, 1'h0);
    meas_win <= 1'h1;
    repeat (3) @(posedge ref_clk_i);
    check("feed window", feed, 1'h1);
    for (int i = 0; i < 5; i++)
    begin
      on_state <= {3{tab[i][0]}};
      mgr <= {3{tab[i][1]}};
      repeat (20) @(posedge ref_clk_i);
      check("paired outputs", drv, {3{tab[i][2]}});
    end
    wr(`MDT_CFG_ADDR, 32'h00);
    rdchk(`MDT_CFG_ADDR, 32'h00);
    mgr <= 6'h15;
    repeat (3) @(posedge ref_clk_i);
    check("six-step direct", drv, 6'h15);
    wr(`MDT_CFG_ADDR, 32'h40);
    rdchk(`MDT_CFG_ADDR, 32'h40);
    $display("test six_step done");
  endtask

  // cuts a hang short well past the expected few thousand cycles
  initial
  begin
    #100000;
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial
  begin
    do_reset();
    stage_rst <= 1'h0;
    t_reset_regs();
    t_codes();
    t_short_pulse();
    t_plain();
    t_six_step();
    check("shorted legs", shoots, 0);
    end_of_test();
  end
endmodule
